// >>> pfis_core.sv
// Purpose: Fault and input-event handling around a four-phase PWM sequence
// Assumes: Inputs synchronous to core_clk; sync clock given as an enable pulse
// Notes:   Four-ramp style sequencing: counter restarts at each phase end
//
// Behaviour
// [RULE_01] Event config selects asynchronous or synchronous detection
// [RULE_02] Async: outputs drop at once, sequence after sync
// [RULE_03] Software never combines async detection with filter
// [RULE_04] Buffer update at cycle end or immediately
// [RULE_05] Restart strobe restarts the counter
// [RULE_06] Soft capture strobes copy counter to holders
// [RULE_07] Each input has its own behaviour select field
// [RULE_08] Software picks modes valid for waveform mode
// [RULE_09] Mode 0 leaves outputs alone, captures still work
// [RULE_10] Mode 1: off, opposite dead, hold until low
// [RULE_11] Mode 1 acts in own phases, resumes opposite
// [RULE_12] Mode 2: run opposite cycle, then wait
// [RULE_13] Mode 3: repeat opposite cycle while fault
// [RULE_14] Modes 2/3 act only in own phases
// [RULE_15] Mode 4 masks both outputs, counter unaltered
// [RULE_16] Mode 5: alternate dead times while fault
// [RULE_17] Mode 6: finish dead time, hold, then next
// [RULE_18] Mode 7 stops until restart; stops again if high
// [RULE_19] Restart after mode 7 begins at dead A
// [RULE_20] Mode 8 edge during on jumps opposite dead
// [RULE_21] Four phases ended by four compare values
// [RULE_22] Synchronous detection takes two to three sync cycles
// [RULE_23] Inputs ignored until enabled; action bit selects capture
// [RULE_24] Codes above ten behave as mode 0
`timescale 1ns/10ps

module pfis_core
    import pfis_pkg::*;
#(
    parameter int CW = pfis_pkg::CNT_W
)
(
    input  wire logic                        core_clk,
    input  wire logic                        reset,
    input  wire logic                        sync_en,
    input  wire logic                        enable,
    input  wire logic                        event_in_a,
    input  wire logic                        event_in_b,
    input  wire logic                        trigger_input_enable_a,
    input  wire logic                        trigger_input_enable_b,
    input  wire logic                        capture_action_a,
    input  wire logic                        capture_action_b,
    input  wire logic [1:0]                  event_control_a,
    input  wire logic [1:0]                  event_control_b,
    input  wire logic [pfis_pkg::MODE_W-1:0] fault_control_a,
    input  wire logic [pfis_pkg::MODE_W-1:0] fault_control_b,
    input  wire logic [CW-1:0]               cmp_a_set_buf,
    input  wire logic [CW-1:0]               cmp_a_clr_buf,
    input  wire logic [CW-1:0]               cmp_b_set_buf,
    input  wire logic [CW-1:0]               cmp_b_clr_buf,
    input  wire logic                        buffer_update_at_cycle_end,
    input  wire logic                        buffer_update_now,
    input  wire logic                        restart_strobe,
    input  wire logic                        soft_capture_a_strobe,
    input  wire logic                        soft_capture_b_strobe,
    output logic                             waveform_out_a,
    output logic                             waveform_out_b,
    output logic [CW-1:0]                    capture_hold_a,
    output logic [CW-1:0]                    capture_hold_b,
    output logic                             capture_valid_a,
    output logic                             capture_valid_b,
    output logic [3:0]                       phase_state,
    output logic                             stopped
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        pfis_phase_t  phase;
        logic [CW-1:0] cnt;
        logic [CW-1:0] cas;
        logic [CW-1:0] cac;
        logic [CW-1:0] cbs;
        logic [CW-1:0] cbc;
        logic          upd_pend;
        logic [1:0]    sa;
        logic [1:0]    sb;
        logic          pa;
        logic          pb;
        logic          fa;
        logic          fb;
        logic          hold;
        logic          stop7;
        logic          rep;
        logic          mask_a;
        logic          mask_b;
        logic          wa;
        logic          wb;
        logic [CW-1:0] hca;
        logic [CW-1:0] hcb;
        logic          cva;
        logic          cvb;
    } pfis_state_t;

    pfis_state_t s_q;
    pfis_state_t s_d;

    // Phase end compare, next-phase and side helpers
    function automatic logic [CW-1:0] phase_limit(input pfis_phase_t p,
                                                  input pfis_state_t s);
        case (p)
            PH_DEAD_A: phase_limit = s.cas;
            PH_ON_A:   phase_limit = s.cac;
            PH_DEAD_B: phase_limit = s.cbs;
            PH_ON_B:   phase_limit = s.cbc;
            default:   phase_limit = s.cbc;
        endcase
    endfunction : phase_limit

    function automatic pfis_phase_t next_phase(input pfis_phase_t p);
        case (p)
            PH_DEAD_A: next_phase = PH_ON_A;
            PH_ON_A:   next_phase = PH_DEAD_B;
            PH_DEAD_B: next_phase = PH_ON_B;
            default:   next_phase = PH_DEAD_A;
        endcase
    endfunction : next_phase

    function automatic logic in_a_side(input pfis_phase_t p);
        in_a_side = (p == PH_DEAD_A) || (p == PH_ON_A);
    endfunction : in_a_side

    // ------------------------------------------------------------------
    // Input qualification
    // ------------------------------------------------------------------
    logic en_a;
    logic en_b;
    logic async_a;
    logic async_b;
    logic m_a [0:8];
    logic m_b [0:8];
    logic any_lvl;
    logic raw_a;
    logic raw_b;

    // Capture action turns the input into a capture trigger only
    assign raw_a   = event_in_a & trigger_input_enable_a & ~capture_action_a;       // RULE_23
    assign raw_b   = event_in_b & trigger_input_enable_b & ~capture_action_b;       // RULE_23
    assign async_a = (event_control_a == EVCFG_ASYNC);                              // RULE_01
    assign async_b = (event_control_b == EVCFG_ASYNC);                              // RULE_01
    // Synchronised levels; async path only shortcuts the output override
    assign en_a    = s_q.fa;                                                        // RULE_22
    assign en_b    = s_q.fb;                                                        // RULE_22

    always_comb
    begin
        for (int i = 0; i <= 8; i++)
        begin
            // Codes 9 and above fall out of every match
            m_a[i] = (fault_control_a == 4'(i));                                   // RULE_07 RULE_24
            m_b[i] = (fault_control_b == 4'(i));                                   // RULE_07 RULE_24
        end
    end

    assign any_lvl = (en_a & (m_a[4] | m_a[5] | m_a[6] | m_a[7]))
                   | (en_b & (m_b[4] | m_b[5] | m_b[6] | m_b[7]));

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic          ph_end;
    logic          ris_a;
    logic          ris_b;
    logic          act_a;
    logic          act_b;
    logic          on_ph;
    pfis_phase_t   np;

    always_comb
    begin
        s_d    = s_q;
        ph_end = 1'b0;
        ris_a  = 1'b0;
        ris_b  = 1'b0;
        act_a  = 1'b0;
        act_b  = 1'b0;
        on_ph  = (s_q.phase == PH_ON_A) || (s_q.phase == PH_ON_B);
        np     = next_phase(s_q.phase);

        // Synchroniser stepped by the sync clock enable
        if (sync_en)
        begin
            s_d.sa = {s_q.sa[0], raw_a};
            s_d.sb = {s_q.sb[0], raw_b};
            s_d.fa = s_q.sa[1];
            s_d.fb = s_q.sb[1];
            s_d.pa = s_q.fa;
            s_d.pb = s_q.fb;
            ris_a  = s_q.sa[1] & ~s_q.fa;
            ris_b  = s_q.sb[1] & ~s_q.fb;
        end

        // Captures work in every mode, including the no-action one
        if (soft_capture_a_strobe | (event_in_a & trigger_input_enable_a & capture_action_a))
        begin
            s_d.hca = s_q.cnt;                                                     // RULE_06 RULE_09
            s_d.cva = 1'b1;
        end
        if (soft_capture_b_strobe | (event_in_b & trigger_input_enable_b & capture_action_b))
        begin
            s_d.hcb = s_q.cnt;                                                     // RULE_06 RULE_09
            s_d.cvb = 1'b1;
        end

        // Buffered compares
        if (buffer_update_now)
        begin
            s_d.cas = cmp_a_set_buf;                                               // RULE_04
            s_d.cac = cmp_a_clr_buf;
            s_d.cbs = cmp_b_set_buf;
            s_d.cbc = cmp_b_clr_buf;
            s_d.upd_pend = 1'b0;
        end
        else if (buffer_update_at_cycle_end)
        begin
            s_d.upd_pend = 1'b1;                                                   // RULE_04
        end

        // Sequence step
        if (enable && !s_q.stop7 && !s_q.hold)
        begin
            ph_end = (s_q.cnt >= phase_limit(s_q.phase, s_q));                     // RULE_21
            if (ph_end)
            begin
                s_d.cnt = CNT_RST;
                // Repeat: keep alternating into the opposite pair
                if (s_q.rep && np == PH_DEAD_A && en_a)                            // RULE_13
                    np = PH_DEAD_B;
                else if (s_q.rep && np == PH_DEAD_B && en_b)
                    np = PH_DEAD_A;
                else if (np == PH_DEAD_A || np == PH_DEAD_B)
                    s_d.rep = 1'b0;                                                // RULE_13
                // Dead-only: while fault lasts skip on time to other dead time
                if (((en_a & m_a[5]) | (en_b & m_b[5])) && (np == PH_ON_A || np == PH_ON_B))
                    np = (np == PH_ON_A) ? PH_DEAD_B : PH_DEAD_A;                  // RULE_16
                // Hold at the end of a dead time while level fault persists
                if (((en_a & m_a[6]) | (en_b & m_b[6])) && (np == PH_ON_A || np == PH_ON_B))
                begin
                    s_d.hold = 1'b1;                                               // RULE_17
                    np = (np == PH_ON_A) ? PH_DEAD_B : PH_DEAD_A;
                end
                // Wait after the opposite pair has run
                if ((s_q.wa && s_q.phase == PH_ON_B) || (s_q.wb && s_q.phase == PH_ON_A))
                begin
                    s_d.wa = 1'b0;
                    s_d.wb = 1'b0;
                    if ((s_q.wa & en_a) | (s_q.wb & en_b))
                        s_d.hold = 1'b1;                                           // RULE_12
                end
                s_d.phase = np;
                if (np == PH_DEAD_A && s_q.phase == PH_ON_B && s_q.upd_pend)
                begin
                    s_d.cas = cmp_a_set_buf;                                       // RULE_04
                    s_d.cac = cmp_a_clr_buf;
                    s_d.cbs = cmp_b_set_buf;
                    s_d.cbc = cmp_b_clr_buf;
                    // A request landing on the cycle end stays pending
                    s_d.upd_pend = buffer_update_at_cycle_end & ~buffer_update_now;
                end
            end
            else
            begin
                s_d.cnt = s_q.cnt + 1'b1;
            end
        end

        // Release of a hold: counter resumes at the phase set on entry
        if (s_q.hold && !((en_a & (m_a[1] | m_a[2])) | (en_b & (m_b[1] | m_b[2])) |
                          (en_a & m_a[6]) | (en_b & m_b[6])))
            s_d.hold = 1'b0;                                                       // RULE_10 RULE_17

        // Input A sided modes act only in dead A or on A
        if (en_a && in_a_side(s_q.phase) && !s_q.hold)
        begin
            if (m_a[1])
            begin
                act_a = 1'b1;                                                      // RULE_10 RULE_11
                s_d.phase = PH_DEAD_B;
                s_d.cnt   = CNT_RST;
                s_d.hold  = 1'b1;
            end
            else if (m_a[2] || m_a[3])
            begin
                act_a = 1'b1;                                                      // RULE_14
                s_d.phase = PH_DEAD_B;
                s_d.cnt   = CNT_RST;
                s_d.wa    = m_a[2];                                                // RULE_12
                s_d.rep   = m_a[3];                                                // RULE_13
            end
        end
        if (en_b && !in_a_side(s_q.phase) && !s_q.hold)
        begin
            if (m_b[1])
            begin
                act_b = 1'b1;                                                      // RULE_10 RULE_11
                s_d.phase = PH_DEAD_A;
                s_d.cnt   = CNT_RST;
                s_d.hold  = 1'b1;
            end
            else if (m_b[2] || m_b[3])
            begin
                act_b = 1'b1;                                                      // RULE_14
                s_d.phase = PH_DEAD_A;
                s_d.cnt   = CNT_RST;
                s_d.wb    = m_b[2];                                                // RULE_12
                s_d.rep   = m_b[3];                                                // RULE_13
            end
        end

        // Edge mode: rising edge during own on time jumps opposite dead
        if (ris_a && m_a[8] && s_q.phase == PH_ON_A)
        begin
            s_d.phase = PH_DEAD_B;                                                 // RULE_20
            s_d.cnt   = CNT_RST;
        end
        if (ris_b && m_b[8] && s_q.phase == PH_ON_B)
        begin
            s_d.phase = PH_DEAD_A;                                                 // RULE_20
            s_d.cnt   = CNT_RST;
        end

        // Mode 5 or 6 fault during on time jumps to opposite dead time
        if (on_ph && ((en_a & (m_a[5] | m_a[6])) | (en_b & (m_b[5] | m_b[6]))))
        begin
            s_d.phase = (s_q.phase == PH_ON_A) ? PH_DEAD_B : PH_DEAD_A;            // RULE_16 RULE_17
            s_d.cnt   = CNT_RST;
        end

        // Software stop mode
        if ((en_a & m_a[7]) | (en_b & m_b[7]))
            s_d.stop7 = 1'b1;                                                      // RULE_18
        if (restart_strobe)
        begin
            s_d.cnt   = CNT_RST;                                                   // RULE_05
            s_d.phase = PH_DEAD_A;                                                 // RULE_19
            s_d.hold  = 1'b0;
            s_d.rep   = 1'b0;
            s_d.wa    = 1'b0;
            s_d.wb    = 1'b0;
            // A fault still high stops the timer again at once
            s_d.stop7 = (en_a & m_a[7]) | (en_b & m_b[7]);                         // RULE_18
        end

        // Output masks held by the synchronised fault
        s_d.mask_a = (en_a & (m_a[1] | m_a[2] | m_a[3]) & (act_a | s_q.mask_a))
                   | (s_q.wa | (s_q.rep & en_a));
        s_d.mask_b = (en_b & (m_b[1] | m_b[2] | m_b[3]) & (act_b | s_q.mask_b))
                   | (s_q.wb | (s_q.rep & en_b));
        if (!enable)
        begin
            s_d.cnt   = CNT_RST;
            s_d.phase = PH_DEAD_A;
        end
    end

    // ------------------------------------------------------------------
    // Waveform outputs
    // ------------------------------------------------------------------
    logic kill_all;
    logic kill_a;
    logic kill_b;
    logic async_all;

    // Asynchronous detection overrides straight from the raw input level
    assign async_all = (async_a & raw_a & (fault_control_a inside {4'h4, 4'h5, 4'h6, 4'h7}))
                     | (async_b & raw_b & (fault_control_b inside {4'h4, 4'h5, 4'h6, 4'h7}));
    assign kill_all  = any_lvl | s_q.stop7 | s_q.hold | async_all;                 // RULE_15 RULE_02
    assign kill_a    = kill_all | s_q.mask_a                                        // RULE_02
                     | (async_a & raw_a & (m_a[1] | m_a[2] | m_a[3] | m_a[8]));
    assign kill_b    = kill_all | s_q.mask_b                                        // RULE_02
                     | (async_b & raw_b & (m_b[1] | m_b[2] | m_b[3] | m_b[8]));

    assign waveform_out_a  = s_q.wa == 1'b0 && !kill_a && enable && s_q.phase == PH_ON_A;
    assign waveform_out_b  = s_q.wb == 1'b0 && !kill_b && enable && s_q.phase == PH_ON_B;
    assign capture_hold_a  = s_q.hca;
    assign capture_hold_b  = s_q.hcb;
    assign capture_valid_a = s_q.cva;
    assign capture_valid_b = s_q.cvb;
    assign phase_state     = s_q.phase;
    assign stopped         = s_q.stop7;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            s_q       <= '0;
            s_q.phase <= PH_DEAD_A;
            s_q.cnt   <= CNT_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_restart_dead_a;
        @(posedge core_clk) disable iff (reset)
        restart_strobe |=> (phase_state == PH_DEAD_A) && (s_q.cnt == CNT_RST);
    endproperty
    a_restart_dead_a: assert property (p_restart_dead_a) else $error("restart not at dead A"); // RULE_19

    property p_stop_kills;
        @(posedge core_clk) disable iff (reset)
        stopped |-> !waveform_out_a && !waveform_out_b;
    endproperty
    a_stop_kills: assert property (p_stop_kills) else $error("output during stop"); // RULE_18

    property p_stop_holds;
        @(posedge core_clk) disable iff (reset)
        stopped && !restart_strobe |=> $stable(s_q.cnt);
    endproperty
    a_stop_holds: assert property (p_stop_holds) else $error("counter moved while stopped"); // RULE_18

    property p_mask_all;
        @(posedge core_clk) disable iff (reset)
        (en_a && m_a[4]) |-> !waveform_out_a && !waveform_out_b;
    endproperty
    a_mask_all: assert property (p_mask_all) else $error("mode 4 output active"); // RULE_15

    property p_cap_a;
        @(posedge core_clk) disable iff (reset)
        soft_capture_a_strobe |=> capture_hold_a == $past(s_q.cnt);
    endproperty
    a_cap_a: assert property (p_cap_a) else $error("capture A wrong value"); // RULE_06

    property p_edge_jump;
        @(posedge core_clk) disable iff (reset)
        ris_a && m_a[8] && phase_state == PH_ON_A && !restart_strobe && enable
            |=> phase_state == PH_DEAD_B;
    endproperty
    a_edge_jump: assert property (p_edge_jump) else $error("edge mode no jump"); // RULE_20

    property p_async_now;
        @(posedge core_clk) disable iff (reset)
        async_a && raw_a && m_a[4] |-> !waveform_out_a;
    endproperty
    a_async_now: assert property (p_async_now) else $error("async override late"); // RULE_02

    property p_mode1_hold;
        @(posedge core_clk) disable iff (reset)
        act_a && m_a[1] && !restart_strobe && enable |=> phase_state == PH_DEAD_B ##0 s_q.hold;
    endproperty
    a_mode1_hold: assert property (p_mode1_hold) else $error("mode 1 no hold"); // RULE_10

endmodule : pfis_core

// >>> pfis_core_tb.sv
// Purpose: Self-checking bench for the fault sequencer
// Assumes: Long phases so a fault settles inside one on time
// Notes:   Mode 7 and capture handled by hand after the table
`timescale 1ns/10ps
module pfis_core_tb;
    import pfis_pkg::*;
    logic core_clk = 0, reset = 1, sync_en = 0, enable = 0, te = 0;
    logic req_a = 0, req_b = 0, upd_now = 0, rst_s = 0, cap_a = 0, cap_b = 0;
    logic upd_eoc = 0, act = 0;
    logic [11:0] ha, hb;
    logic [1:0] evc = 2'h0;
    logic [3:0] fc = 4'h0;
    logic [11:0] cmp = 12'h000;
    logic ev_a, ev_b, wa, wb, va, vb, stopped;
    logic [3:0] phase_state;
    int fails = 0, comparisons = 0;
    // Fields: mode, event config, outs two cycles after, outs later, phase later
    logic [13:0] rows [10] = '{{4'h0, 2'h0, 2'h2, 2'h2, 4'h2}, {4'hC, 2'h0, 2'h2, 2'h2, 4'h2},
        {4'h4, 2'h0, 2'h2, 2'h0, 4'h2}, {4'h4, 2'h2, 2'h0, 2'h0, 4'h2},
        {4'h1, 2'h0, 2'h2, 2'h0, 4'h4}, {4'h2, 2'h0, 2'h2, 2'h0, 4'h4},
        {4'h3, 2'h0, 2'h2, 2'h0, 4'h4}, {4'h5, 2'h0, 2'h2, 2'h0, 4'h4},
        {4'h6, 2'h0, 2'h2, 2'h0, 4'h4}, {4'h8, 2'h0, 2'h2, 2'h0, 4'h4}};
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) sync_en <= ~sync_en;
    pfis_evnet i_pfis_evnet (.core_clk(core_clk), .req_a(req_a), .req_b(req_b),
        .event_in_a(ev_a), .event_in_b(ev_b));
    pfis_core i_pfis_core (.core_clk(core_clk), .reset(reset), .sync_en(sync_en),
        .enable(enable), .event_in_a(ev_a), .event_in_b(ev_b),
        .trigger_input_enable_a(te), .trigger_input_enable_b(te),
        .capture_action_a(act), .capture_action_b(act),
        .event_control_a(evc), .event_control_b(evc), .fault_control_a(fc),
        .fault_control_b(fc), .cmp_a_set_buf(cmp), .cmp_a_clr_buf(cmp),
        .cmp_b_set_buf(cmp), .cmp_b_clr_buf(cmp), .buffer_update_at_cycle_end(upd_eoc),
        .buffer_update_now(upd_now), .restart_strobe(rst_s),
        .soft_capture_a_strobe(cap_a), .soft_capture_b_strobe(cap_b),
        .waveform_out_a(wa), .waveform_out_b(wb), .capture_hold_a(ha),
        .capture_hold_b(hb), .capture_valid_a(va), .capture_valid_b(vb),
        .phase_state(phase_state), .stopped(stopped));
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    task automatic finish_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic wait_ph(input logic [3:0] ph);
        int n;
        n = 0;
        while (phase_state !== ph && n < 400)
        begin
            tick(1);
            n++;
        end
        chk("phase", ph, phase_state);
        if (n == 400)
            finish_test();
    endtask : wait_ph
    task automatic restart;
        rst_s = 1;
        tick(1);
        rst_s = 0;
    endtask : restart
    initial
    begin
        tick(4);
        reset = 0;
        chk("phase", 4'h1, phase_state);
        chk("outs", 4'h0, {2'b00, wa, wb});
        cmp = 12'h02F;
        upd_now = 1;
        tick(1);
        upd_now = 0;
        enable = 1;
        te = 1;
        restart();
        foreach (rows[i])
        begin
            {fc, evc} = rows[i][13:8];
            wait_ph(4'h2);
            req_a = 1;
            tick(2);
            chk("outs early", {2'b00, rows[i][7:6]}, {2'b00, wa, wb});
            tick(10);
            chk("outs late", {2'b00, rows[i][5:4]}, {2'b00, wa, wb});
            chk("phase late", rows[i][3:0], phase_state);
            req_a = 0;
            // Let the synchronised fault drop before restarting
            tick(10);
            restart();
        end
        fc = 4'h1;
        wait_ph(4'h2);
        req_b = 1;
        tick(12);
        chk("phase", 4'h2, phase_state);
        req_b = 0;
        fc = 4'h7;
        req_a = 1;
        tick(12);
        chk("stopped", 4'h1, {3'h0, stopped});
        restart();
        tick(12);
        chk("stopped", 4'h1, {3'h0, stopped});
        req_a = 0;
        tick(10);
        restart();
        chk("phase", 4'h1, phase_state);
        chk("stopped", 4'h0, {3'h0, stopped});
        te = 0;
        req_a = 1;
        tick(12);
        chk("stopped", 4'h0, {3'h0, stopped});
        cap_a = 1;
        tick(1);
        cap_a = 0;
        chk("valid", 4'h2, {2'b00, va, vb});
        cap_b = 1;
        tick(1);
        cap_b = 0;
        chk("valid", 4'h3, {2'b00, va, vb});
        chk("hold a", 12'h00C, ha);
        chk("hold b", 12'h00D, hb);
        cmp = 12'h00F;
        upd_eoc = 1;
        tick(1);
        upd_eoc = 0;
        tick(20);
        chk("phase", 4'h1, phase_state);
        wait_ph(4'h8);
        chk("outs", 4'h1, {2'b00, wa, wb});
        wait_ph(4'h1);
        tick(16);
        chk("phase", 4'h2, phase_state);
        te = 1;
        act = 1;
        tick(4);
        chk("hold a", 12'h003, ha);
        chk("stopped", 4'h0, {3'h0, stopped});
        finish_test();
    end
endmodule : pfis_core_tb

// >>> pfis_evnet.sv
// Purpose: Model of the event routing network feeding the fault inputs
// Assumes: Routed events arrive one core clock after the request
// Notes:   Never combines async detection with filtering
`timescale 1ns/10ps
module pfis_evnet
(
    input  wire logic core_clk,
    input  wire logic req_a,
    input  wire logic req_b,
    output logic      event_in_a,
    output logic      event_in_b
);
    // One register stage, as a real routing network adds
    always_ff @(posedge core_clk)
    begin
        event_in_a <= req_a;
        event_in_b <= req_b;
    end
endmodule : pfis_evnet

// >>> pfis_pkg.sv
// Purpose: Shared constants and types for the PWM fault and input-event sequencer
// Assumes: One core clock; all control bits arrive as plain ports
// Notes:   Codes for fault behaviour follow the four-bit selector field
package pfis_pkg;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int          CNT_W        = 12;
    localparam int          MODE_W       = 4;
    localparam logic [11:0] CNT_RST      = 12'h000;
    localparam logic [11:0] CMP_RST      = 12'h000;
    localparam int          SYNC_STAGES  = 2;

    // ------------------------------------------------------------------
    // Fault behaviour codes
    // ------------------------------------------------------------------
    localparam logic [3:0] FB_NONE       = 4'h0;
    localparam logic [3:0] FB_JUMP_WAIT  = 4'h1;
    localparam logic [3:0] FB_RUN_WAIT   = 4'h2;
    localparam logic [3:0] FB_REPEAT     = 4'h3;
    localparam logic [3:0] FB_MASK_ALL   = 4'h4;
    localparam logic [3:0] FB_DEAD_ONLY  = 4'h5;
    localparam logic [3:0] FB_ALL_WAIT   = 4'h6;
    localparam logic [3:0] FB_STOP_SW    = 4'h7;
    localparam logic [3:0] FB_EDGE_JUMP  = 4'h8;

    // Event configuration: asynchronous detection code
    localparam logic [1:0] EVCFG_ASYNC   = 2'h2;

    // ------------------------------------------------------------------
    // Sequence phases
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        PH_DEAD_A = 4'b0001,
        PH_ON_A   = 4'b0010,
        PH_DEAD_B = 4'b0100,
        PH_ON_B   = 4'b1000
    } pfis_phase_t;

endpackage : pfis_pkg
